// file: logic/slsd_pkg.sv
// Shared constants and types for the serial LCD segment driver
package slsd_pkg;
	localparam int SR_W          = 38;   // Shift register and latch width
	localparam int LAST_STAGE    = 38;   // Cascade tap: 30, 32 or 38
	localparam logic [37:0] SR_RST  = 38'h0000000000;
	localparam logic        BIT_RST = 1'h0;
	localparam int CLK_PERIOD_NS = 100;  // clk_sys at 10 MHz
	localparam int OSC_HALF_NS   = 1000; // Internal oscillator half period
	localparam int OSC_HALF_CYC  =
		(OSC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BP_HALF_OSC   = 128;  // Oscillator periods per half
	localparam logic [6:0] DIV_LAST = 7'(BP_HALF_OSC - 1);
	localparam int MISMATCH_CYC  = 4;    // Fight samples before external
	localparam int EXT_IDLE_US   = 20000; // Silence before self mode
	localparam int EXT_IDLE_CYC  =
		EXT_IDLE_US * 1000 / CLK_PERIOD_NS;
	localparam int STABLE_CYC    = 2;    // Quiet cycles before word sample
	localparam int BUF_DEPTH     = 2;
	typedef enum logic {
		MODE_SELF,
		MODE_EXT
	} slsd_osc_mode_t;
endpackage

// file: logic/slsd_fifo2.sv
// Small synchronous buffer with valid and ready on both sides
`timescale 1ns/10ps
module slsd_fifo2 #(
	parameter int W     = 38,
	parameter int DEPTH = 2
) (
	input  wire logic         clk_sys,
	input  wire logic         sys_rst,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [W-1:0]  mem_q [DEPTH];
	logic [PW-1:0] wr_q;
	logic [PW-1:0] rd_q;
	logic [CW-1:0] cnt_q;
	logic          push;
	logic          pop;

	// Handshakes come straight from the fill count
	assign in_ready  = (cnt_q != CW'(DEPTH));
	assign out_valid = (cnt_q != '0);
	assign out_data  = mem_q[rd_q];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// Storage is not reset; the count guards every read
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
		end
	end

	// Fill count
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			cnt_q <= '0;
		end else if (push && !pop) begin
			cnt_q <= cnt_q + 1'b1;
		end else if (pop && !push) begin
			cnt_q <= cnt_q - 1'b1;
		end
	end
endmodule

// file: logic/slsd_top.sv
// Serial-in latched LCD segment driver with backplane generator
// What this block does
// - Each falling sclk edge with chip select low shifts data in at stage 1 and moves every bit on.
// - The cascade output changes only on the rising serial clock edge.
// - Stage n holds the input that was present n clock pulses earlier.
// - Data enters at stage 1 and the cascade output taps stage 30, 32 or 38.
// - A latched one drives its segment in antiphase to the backplane.
// - While load is high the latches take the whole shift register.
// - Load held high during shifting keeps the latches transparent.
// - The falling edge of load closes the latches on the current contents.
// - The block finds by itself whether the oscillator pin is driven.
// - Self oscillating, the backplane is the oscillator divided by 256.
// - Driven externally, the backplane follows the pin in phase.
// - A latched zero drives its segment in phase with the backplane.
// - With chip select high the shift register ignores clock edges.
// - With chip select high the load strobe is ignored.
`timescale 1ns/10ps
module slsd_top #(
	parameter int unsigned LAST_STAGE   = slsd_pkg::LAST_STAGE,
	parameter int unsigned EXT_IDLE_CYC = slsd_pkg::EXT_IDLE_CYC
) (
	input  wire logic                      clk_sys,
	input  wire logic                      sys_rst,
	input  wire logic                      sclk,
	input  wire logic                      data_in,
	input  wire logic                      cs_n,
	input  wire logic                      load,
	input  wire logic                      backplane_osc_pin_i,
	output logic                           backplane_osc_pin_o,
	output logic                           backplane_osc_pin_oe_n,
	output logic                           data_out,
	output logic                           backplane,
	output logic [slsd_pkg::SR_W-1:0]      seg
);
	localparam int SR_W = slsd_pkg::SR_W;

	// Link domain state
	logic            lrst_m_q;
	logic            lrst_q;
	logic [SR_W-1:0] sr_q;
	logic            tgl_q;
	logic            dout_q;

	// System domain state
	logic            tgl_m_q;
	logic            tgl_s_q;
	logic            tgl_d_q;
	logic [SR_W-1:0] wrd_m_q;
	logic [SR_W-1:0] wrd_s_q;
	logic [1:0]      quiet_q;
	logic [SR_W-1:0] last_q;
	logic            cs_m_q;
	logic            cs_s_q;
	logic            ld_m_q;
	logic            ld_s_q;
	logic [SR_W-1:0] latch_q;
	logic [SR_W-1:0] seg_q;
	logic            bp_q;
	logic            bp_out_q;
	logic            settled;
	logic            push_valid;
	logic            push_ready;
	logic            f_out_valid;
	logic [SR_W-1:0] f_out_data;
	logic            load_en;

	// Oscillator and mode detection
	slsd_pkg::slsd_osc_mode_t mode_q;
	logic [3:0]      osc_cnt_q;
	logic            osc_q;
	logic            osc_d1_q;
	logic            osc_d2_q;
	logic            osc_rise;
	logic            pin_m_q;
	logic            pin_s_q;
	logic            pin_d_q;
	logic [2:0]      mism_q;
	logic [31:0]     idle_q;
	logic [6:0]      div_q;

	// Reset brought into the serial clock domain; stands while sclk idles
	always_ff @(negedge sclk) begin
		lrst_m_q <= sys_rst;
		lrst_q   <= lrst_m_q;
	end

	// Shift on the falling edge, only while selected
	always_ff @(negedge sclk) begin
		if (lrst_q) begin
			sr_q  <= slsd_pkg::SR_RST;
			tgl_q <= slsd_pkg::BIT_RST;
		end else if (!cs_n) begin
			sr_q  <= {sr_q[SR_W-2:0], data_in};
			tgl_q <= ~tgl_q;
		end
	end

	// Cascade output moves half a cycle after the shift
	always_ff @(posedge sclk) begin
		if (lrst_q) begin
			dout_q <= slsd_pkg::BIT_RST;
		end else begin
			dout_q <= sr_q[LAST_STAGE-1];
		end
	end
	assign data_out = dout_q;

	// Shift activity toggle and pins pass two flip-flops into clk_sys
	always_ff @(posedge clk_sys) begin
		tgl_m_q <= tgl_q;
		tgl_s_q <= tgl_m_q;
		cs_m_q  <= cs_n;
		cs_s_q  <= cs_m_q;
		ld_m_q  <= load;
		ld_s_q  <= ld_m_q;
		pin_m_q <= backplane_osc_pin_i;
		pin_s_q <= pin_m_q;
	end

	// The word is sampled freely but trusted only once shifting is quiet;
	// bursts faster than clk_sys show only their settled end state
	always_ff @(posedge clk_sys) begin
		wrd_m_q <= sr_q;
		wrd_s_q <= wrd_m_q;
	end

	// Quiet counter restarts on every synchronised shift
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			tgl_d_q <= slsd_pkg::BIT_RST;
			quiet_q <= '0;
		end else begin
			tgl_d_q <= tgl_s_q;
			if (tgl_s_q != tgl_d_q) begin
				quiet_q <= '0;
			end else if (!settled) begin
				quiet_q <= quiet_q + 1'b1;
			end
		end
	end
	assign settled    = (quiet_q == 2'(slsd_pkg::STABLE_CYC));
	// A shift seen by the toggle pair one cycle before the quiet counter
	// clears would otherwise let a half shifted word into the buffer
	assign push_valid = settled && (tgl_s_q == tgl_d_q)
		&& (wrd_s_q != last_q);

	// Last word offered to the buffer; waits while the buffer is full
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			last_q <= slsd_pkg::SR_RST;
		end else if (push_valid && push_ready) begin
			last_q <= wrd_s_q;
		end
	end

	// Buffer drains only while the latches are open, so it can fill
	slsd_fifo2 #(
		.W     (SR_W),
		.DEPTH (slsd_pkg::BUF_DEPTH)
	) u_buf (
		.clk_sys   (clk_sys),
		.sys_rst   (sys_rst),
		.in_valid  (push_valid),
		.in_ready  (push_ready),
		.in_data   (wrd_s_q),
		.out_valid (f_out_valid),
		.out_ready (load_en),
		.out_data  (f_out_data)
	);

	// Load counts only while chip select is active
	assign load_en = ld_s_q && !cs_s_q;

	// Output latches: open while load is high, closed after its fall
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			latch_q <= slsd_pkg::SR_RST;
		end else if (load_en && f_out_valid) begin
			latch_q <= f_out_data;
		end
	end

	// Internal RC oscillator stand-in
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			osc_cnt_q <= '0;
			osc_q     <= slsd_pkg::BIT_RST;
		end else if (osc_cnt_q == 4'(slsd_pkg::OSC_HALF_CYC - 1)) begin
			osc_cnt_q <= '0;
			osc_q     <= ~osc_q;
		end else begin
			osc_cnt_q <= osc_cnt_q + 1'b1;
		end
	end
	assign osc_rise = !osc_q && (osc_cnt_q == 4'(slsd_pkg::OSC_HALF_CYC - 1));

	// Expected pin level, aligned with the synchroniser delay
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			osc_d1_q <= slsd_pkg::BIT_RST;
			osc_d2_q <= slsd_pkg::BIT_RST;
			pin_d_q  <= slsd_pkg::BIT_RST;
		end else begin
			osc_d1_q <= osc_q;
			osc_d2_q <= osc_d1_q;
			pin_d_q  <= pin_s_q;
		end
	end

	// Pin drive; released once an outside driver is seen
	assign backplane_osc_pin_o    = osc_q;
	assign backplane_osc_pin_oe_n = (mode_q == slsd_pkg::MODE_EXT);

	// Mode detection: a driver that overpowers ours means external mode;
	// a long silence on the released pin hands control back to us
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			mode_q <= slsd_pkg::MODE_SELF;
			mism_q <= '0;
			idle_q <= '0;
		end else begin
			unique case (mode_q)
				slsd_pkg::MODE_SELF: begin
					idle_q <= '0;
					if (pin_s_q == osc_d2_q) begin
						mism_q <= '0;
					end else if (mism_q == 3'(slsd_pkg::MISMATCH_CYC - 1)) begin
						mism_q <= '0;
						mode_q <= slsd_pkg::MODE_EXT;
					end else begin
						mism_q <= mism_q + 1'b1;
					end
				end
				slsd_pkg::MODE_EXT: begin
					mism_q <= '0;
					if (pin_s_q != pin_d_q) begin
						idle_q <= '0;
					end else if (idle_q == 32'(EXT_IDLE_CYC - 1)) begin
						idle_q <= '0;
						mode_q <= slsd_pkg::MODE_SELF;
					end else begin
						idle_q <= idle_q + 1'b1;
					end
				end
			endcase
		end
	end

	// Backplane: divide by 256 as a square wave, or follow the pin
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			div_q <= '0;
			bp_q  <= slsd_pkg::BIT_RST;
		end else if (mode_q == slsd_pkg::MODE_EXT) begin
			div_q <= '0;
			bp_q  <= pin_s_q;
		end else if (osc_rise) begin
			div_q <= div_q + 1'b1;
			if (div_q == slsd_pkg::DIV_LAST) begin
				bp_q <= ~bp_q;
			end
		end
	end

	// Segments and backplane leave on the same edge so the phase is exact
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			bp_out_q <= slsd_pkg::BIT_RST;
			seg_q    <= slsd_pkg::SR_RST;
		end else begin
			bp_out_q <= bp_q;
			seg_q    <= {SR_W{bp_q}} ^ latch_q;
		end
	end
	assign backplane = bp_out_q;
	assign seg       = seg_q;

	// Checks on the link side
	a_shift_step: assert property (@(negedge sclk) disable iff (lrst_q)
		!cs_n |=> sr_q == {$past(sr_q[SR_W-2:0]), $past(data_in)})
		else $error("shift register did not take one step");
	a_shift_hold: assert property (@(negedge sclk) disable iff (lrst_q)
		cs_n && !lrst_q |=> $stable(sr_q))
		else $error("shift register moved while deselected");
	a_cascade_tap: assert property (@(negedge sclk) disable iff (lrst_q)
		!$past(lrst_q) |-> dout_q == sr_q[LAST_STAGE-1])
		else $error("cascade output not at the last stage");

	// Checks on the system side
	a_seg_phase: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!$past(sys_rst) |-> seg_q == ({SR_W{bp_out_q}} ^ $past(latch_q)))
		else $error("segment phase does not match latch and backplane");
	a_latch_closed: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(!ld_s_q || cs_s_q) |=> $stable(latch_q))
		else $error("latch changed while closed or deselected");
	a_latch_open: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(load_en && f_out_valid) |=> latch_q == $past(f_out_data))
		else $error("open latch did not take buffered word");
	a_ext_follow: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(mode_q == slsd_pkg::MODE_EXT) |=> bp_q == $past(pin_s_q))
		else $error("backplane does not follow driven pin");
	a_bp_toggle: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(mode_q == slsd_pkg::MODE_SELF && osc_rise
		 && div_q == slsd_pkg::DIV_LAST) |=> bp_q != $past(bp_q))
		else $error("backplane missed its toggle");
	a_bp_steady: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(mode_q == slsd_pkg::MODE_SELF
		 && !(osc_rise && div_q == slsd_pkg::DIV_LAST)) |=> $stable(bp_q))
		else $error("backplane toggled off the divide point");
	a_ext_detect: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(mode_q == slsd_pkg::MODE_SELF && pin_s_q != osc_d2_q)[*4]
		|-> ##1 mode_q == slsd_pkg::MODE_EXT)
		else $error("driven pin not detected");

	c_load_pulse: cover property (@(posedge clk_sys) disable iff (sys_rst)
		load_en ##1 !load_en);
	c_buf_full: cover property (@(posedge clk_sys) disable iff (sys_rst)
		push_valid && !push_ready);
	c_ext_mode: cover property (@(posedge clk_sys) disable iff (sys_rst)
		mode_q == slsd_pkg::MODE_SELF ##1 mode_q == slsd_pkg::MODE_EXT);
	c_bp_flip: cover property (@(posedge clk_sys) disable iff (sys_rst)
		mode_q == slsd_pkg::MODE_SELF && $rose(bp_q));
endmodule

// file: tb/slsd_host_model.sv
// Host side model: serial clock frames and serial data line
`timescale 1ns/10ps
module slsd_host_model (
	output logic sclk,
	output logic data_in,
	input  logic cascade_in
);
	// Next device in the chain shifts our cascade output on the same clock
	logic [37:0] chain_q;
	always @(negedge sclk) begin
		chain_q <= {chain_q[36:0], cascade_in};
	end
	// Serial clock idles high and runs only inside a frame or for bare reset pulses
	initial begin
		sclk = 1'b1;
		data_in = 1'b0;
	end
	// Bare clock pulses, used to walk the link side out of reset
	task automatic pulse(input int n);
		repeat (n) begin
			#15 sclk = 1'b0;
			#15 sclk = 1'b1;
		end
	endtask
	// Upper bit goes first so it ends in the deepest stage
	task automatic send(input logic [37:0] w);
		for (int i = 37; i >= 0; i--) begin
			data_in = w[i];
			#15 sclk = 1'b0;
			#15 sclk = 1'b1;
		end
		data_in = ~data_in; // Released line must not keep the last bit
	endtask
endmodule

// file: tb/slsd_top_tb_top.sv
// Self-checking bench for the serial LCD segment driver
`timescale 1ns/10ps
module slsd_top_tb_top;
	localparam int IDLE = 200;
	// Backplane half period in clk_sys cycles: 128 full oscillator periods
	localparam int BP_HALF = 2 * slsd_pkg::BP_HALF_OSC
		* slsd_pkg::OSC_HALF_CYC;
	logic        clk_sys = 1'b0;
	logic        sys_rst = 1'b1;
	logic        cs_n    = 1'b1;
	logic        load    = 1'b0;
	logic        ext_en  = 1'b0;
	logic        ext_val = 1'b0;
	logic        sclk;
	logic        data_in;
	logic        pin_o;
	logic        oe_n;
	logic        pin_i;
	logic        data_out;
	logic        backplane;
	logic [37:0] seg;
	logic [37:0] w[6];
	int          fails = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          n;
	always #50 clk_sys = ~clk_sys;
	// Pin level: outside driver wins, pull-up when nobody drives
	assign pin_i = ext_en ? ext_val : (oe_n ? 1'b1 : pin_o);
	slsd_host_model i_host (.sclk(sclk), .data_in(data_in),
		.cascade_in(data_out));
	slsd_top #(.LAST_STAGE(38), .EXT_IDLE_CYC(IDLE)) i_dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .sclk(sclk),
		.data_in(data_in), .cs_n(cs_n), .load(load),
		.backplane_osc_pin_i(pin_i), .backplane_osc_pin_o(pin_o),
		.backplane_osc_pin_oe_n(oe_n), .data_out(data_out),
		.backplane(backplane), .seg(seg));
	// Segment is the latch bit xor the backplane level
	function automatic logic [37:0] exp_seg(logic [37:0] v, logic bp);
		return v ^ {38{bp}};
	endfunction
	task automatic tick(input int k);
		repeat (k) @(posedge clk_sys);
	endtask
	task automatic chk_vec(input logic [37:0] got, input logic [37:0] exp);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_bit(input logic got, input logic exp);
		chk_vec({37'h0, got}, {37'h0, exp});
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Count edges until the backplane (sel low) or the pin changes, bounded
	task automatic sig_gap(input logic sel, output int k);
		logic b;
		b = sel ? pin_o : backplane;
		k = 0;
		while ((sel ? pin_o : backplane) === b && k < 6000) begin
			tick(1);
			k++;
		end
	endtask
	// Hang guard sized well above the longest expected run
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			conclude();
		end
	end
	initial begin
		void'($urandom(58));
		foreach (w[i]) w[i] = 38'({$urandom, $urandom});
		w[3] = 38'h3FFFFFFFFF; // Corner case: every segment on
		// Link side reset needs sclk edges while reset is held
		fork
			i_host.pulse(6);
			tick(16);
		join
		sys_rst <= 1'b0;
		tick(2);
		i_host.pulse(3);
		// Shift with load low, then open the latches
		cs_n <= 1'b0;
		tick(1);
		i_host.send(w[0]);
		#5 chk_bit(data_out, w[0][37]);
		tick(1);
		load <= 1'b1;
		tick(12);
		chk_vec(seg, exp_seg(w[0], backplane));
		load <= 1'b0;
		tick(4);
		$display("test shift_load done");
		// Closed latch holds; held load is transparent
		i_host.send(w[1]);
		tick(12);
		chk_vec(seg, exp_seg(w[0], backplane));
		chk_vec(i_host.chain_q, w[0]);
		load <= 1'b1;
		tick(2);
		i_host.send(w[2]);
		tick(12);
		chk_vec(seg, exp_seg(w[2], backplane));
		load <= 1'b0;
		tick(4);
		i_host.send(w[3]);
		#5 chk_bit(data_out, w[3][37]);
		tick(12);
		chk_vec(seg, exp_seg(w[2], backplane));
		$display("test transparent done");
		// Deselected: no shifting and no loading
		i_host.send(w[4]);
		tick(2);
		cs_n <= 1'b1;
		load <= 1'b1;
		tick(4);
		i_host.send(w[5]);
		tick(12);
		chk_vec(seg, exp_seg(w[2], backplane));
		chk_bit(data_out, w[4][37]);
		cs_n <= 1'b0;
		tick(12);
		chk_vec(seg, exp_seg(w[4], backplane));
		load <= 1'b0;
		$display("test deselect done");
		// Self mode: half period of 128 oscillator periods
		sig_gap(1'b0, n);
		for (int i = 0; i < 2; i++) begin
			sig_gap(1'b0, n);
			chk_vec(38'(n), 38'(BP_HALF));
		end
		chk_bit(oe_n, 1'b0);
		sig_gap(1'b1, n);
		sig_gap(1'b1, n);
		chk_vec(38'(n), 38'(slsd_pkg::OSC_HALF_CYC));
		$display("test self_osc done");
		// Outside driver is sensed, followed, then released
		ext_en <= 1'b1;
		ext_val <= ~pin_o;
		tick(30);
		chk_bit(oe_n, 1'b1);
		for (int i = 0; i < 4; i++) begin
			ext_val <= ($urandom % 2) ? ~ext_val : ext_val;
			tick(20);
			chk_bit(backplane, ext_val);
			chk_vec(seg, exp_seg(w[4], backplane));
			ext_val <= ~ext_val;
			tick(20);
			chk_bit(backplane, ext_val);
		end
		ext_en <= 1'b0;
		tick(IDLE + 40);
		chk_bit(oe_n, 1'b0);
		$display("test ext_osc done");
		conclude();
	end
endmodule
